// file: hw/fbe_pkg.sv
// Notes on behaviour
// - Boost flag accelerates next 64KB erase
// - Boost flag accelerates next chip erase
// - Boost clears at reset, block erase done
// - Boost clears on chip erase done
// - Power-up lands in standby, not sleep
// - Write latch cleared at power-up
// - Reads accepted after supply settle delay
// - Below threshold, logic reset, commands ignored
// - Latch needed; cleared when operation completes
package fbe_pkg;
    // Decoded command kinds from the shift front end
    typedef enum logic [7:0] {
        FBE_CMD_NONE  = 8'h01,
        FBE_CMD_WLS   = 8'h02,
        FBE_CMD_BOOST = 8'h04,
        FBE_CMD_BE64  = 8'h08,
        FBE_CMD_CE    = 8'h10,
        FBE_CMD_PGM   = 8'h20,
        FBE_CMD_READ  = 8'h40,
        FBE_CMD_OTHER = 8'h80
    } fbe_cmd_t;

    // One completed command framed by chip select
    typedef struct packed {
        logic     valid;
        logic     lone;   // Chip select rose right after the code byte
        fbe_cmd_t kind;
    } fbe_req_t;

    typedef enum logic [2:0] {
        FBE_ST_SETTLE = 3'h1,
        FBE_ST_IDLE   = 3'h2,
        FBE_ST_BUSY   = 3'h4
    } fbe_state_t;

    localparam int unsigned FBE_CLK_HZ       = 10_000_000;
    localparam int unsigned FBE_SETTLE_US    = 800;
    localparam int unsigned FBE_SETTLE_CYC   =
        (FBE_SETTLE_US * (FBE_CLK_HZ / 1_000_000) > 0) ?
        FBE_SETTLE_US * (FBE_CLK_HZ / 1_000_000) : 1;
    localparam int unsigned FBE_CNT_W        = 24;
endpackage

// file: hw/fbe_core.sv
`timescale 1ns/1ns
`default_nettype none
module fbe_core #(
    parameter int unsigned SETTLE_CYC = fbe_pkg::FBE_SETTLE_CYC
) (
    input  wire logic             clk,         // 10 MHz core clock
    input  wire logic             rstn,        // Power-on reset, low below threshold
    input  wire fbe_pkg::fbe_req_t req,        // Decoded command, one-cycle valid
    input  wire logic             op_done,     // Erase/program engine finished
    output logic                  ready_q,     // Settle delay elapsed
    output logic                  busy_q,      // Self-timed operation running
    output logic                  deep_pd_q,   // Deep power-down state
    output logic                  write_enable_latch_flag_q, // Write latch
    output logic                  boost_q,     // factory_boost_enable flag
    output logic                  start_q,     // One-cycle launch of an operation
    output logic                  fast_q,      // Launched erase is accelerated
    output fbe_pkg::fbe_cmd_t     op_kind_q,   // Kind of launched operation
    output logic                  read_ok_q    // Read command accepted pulse
);
    localparam logic [fbe_pkg::FBE_CNT_W-1:0] SETTLE_LAST =
        fbe_pkg::FBE_CNT_W'(SETTLE_CYC - 1);

    fbe_pkg::fbe_state_t          st_q, st_d;
    logic [fbe_pkg::FBE_CNT_W-1:0] cnt_q, cnt_d;
    logic write_enable_latch_flag_d;
    logic boost_d, start_d, fast_d, read_ok_d;
    // Status next values, kept apart from the command state
    logic ready_d, busy_d, deep_pd_d;
    fbe_pkg::fbe_cmd_t kind_d;
    logic erase_req;

    // Next-state logic; commands only count once idle
    always_comb begin
        st_d      = st_q;
        cnt_d     = cnt_q;
        write_enable_latch_flag_d = write_enable_latch_flag_q;
        boost_d   = boost_q;
        start_d   = 1'b0;
        fast_d    = fast_q;
        kind_d    = op_kind_q;
        read_ok_d = 1'b0;
        erase_req = 1'b0;
        unique case (st_q)
            fbe_pkg::FBE_ST_SETTLE: begin
                if (cnt_q == SETTLE_LAST) begin
                    st_d = fbe_pkg::FBE_ST_IDLE;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            fbe_pkg::FBE_ST_IDLE: begin
                if (req.valid) begin
                    unique case (req.kind)
                        fbe_pkg::FBE_CMD_WLS: begin
                            write_enable_latch_flag_d = 1'b1;
                        end
                        fbe_pkg::FBE_CMD_BOOST: begin
                            if (req.lone && write_enable_latch_flag_q) begin
                                boost_d = 1'b1;
                            end
                        end
                        fbe_pkg::FBE_CMD_BE64,
                        fbe_pkg::FBE_CMD_CE,
                        fbe_pkg::FBE_CMD_PGM: erase_req = 1'b1;
                        fbe_pkg::FBE_CMD_READ: read_ok_d = 1'b1;
                        default: ;
                    endcase
                end
                // latch gates erase
                // Without the latch the request is dropped silently
                if (erase_req && write_enable_latch_flag_q) begin
                    start_d = 1'b1;
                    kind_d  = req.kind;
                    fast_d  = boost_q &&
                              (req.kind != fbe_pkg::FBE_CMD_PGM);
                    st_d    = fbe_pkg::FBE_ST_BUSY;
                end
            end
            fbe_pkg::FBE_ST_BUSY: begin
                if (op_done) begin
                    write_enable_latch_flag_d = 1'b0;
                    if (op_kind_q != fbe_pkg::FBE_CMD_PGM) begin
                        boost_d = 1'b0;
                    end
                    fast_d = 1'b0;
                    st_d   = fbe_pkg::FBE_ST_IDLE;
                end
            end
        endcase
    end

    // Register stage; async reset is the power-on reset
    // reset holds all logic
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q      <= fbe_pkg::FBE_ST_SETTLE;
            cnt_q     <= '0;
            write_enable_latch_flag_q <= 1'b0;
            boost_q   <= 1'b0;
            start_q   <= 1'b0;
            fast_q    <= 1'b0;
            op_kind_q <= fbe_pkg::FBE_CMD_NONE;
            read_ok_q <= 1'b0;
        end else begin
            st_q      <= st_d;
            cnt_q     <= cnt_d;
            write_enable_latch_flag_q <= write_enable_latch_flag_d;
            boost_q   <= boost_d;
            start_q   <= start_d;
            fast_q    <= fast_d;
            op_kind_q <= kind_d;
            read_ok_q <= read_ok_d;
        end
    end

    // Status follows the next state so it lines up with st_q
    always_comb begin
        deep_pd_d = 1'b0;
        ready_d   = (st_d != fbe_pkg::FBE_ST_SETTLE);
        busy_d    = (st_d == fbe_pkg::FBE_ST_BUSY);
    end

    // standby, never deep power-down at power-up
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            deep_pd_q <= 1'b0;
            ready_q   <= 1'b0;
            busy_q    <= 1'b0;
        end else begin
            deep_pd_q <= deep_pd_d;
            ready_q   <= ready_d;
            busy_q    <= busy_d;
        end
    end
endmodule
`default_nettype wire

// file: test/fbe_checker.sv
`timescale 1ns/1ns
`default_nettype none
module fbe_checker #(
    parameter int SETTLE_CYC = 10
) (
    input wire logic              clk,
    input wire logic              rstn,
    input wire fbe_pkg::fbe_req_t req,
    input wire logic              op_done,
    input wire logic              ready_q,
    input wire logic              busy_q,
    input wire logic              deep_pd_q,
    input wire logic              write_enable_latch_flag_q,
    input wire logic              boost_q,
    input wire logic              start_q,
    input wire logic              fast_q,
    input wire fbe_pkg::fbe_cmd_t op_kind_q,
    input wire logic              read_ok_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Taken only when settled and not busy
    wire take = req.valid && ready_q && !busy_q;
    sequence boosted_erase;
        take && boost_q && write_enable_latch_flag_q && req.kind inside
            {fbe_pkg::FBE_CMD_BE64, fbe_pkg::FBE_CMD_CE};
    endsequence
    boost_take_a: assert property (boosted_erase |=> start_q && fast_q
        && op_kind_q == $past(req.kind)) else $error("erase not boosted");
    boost_set_a: assert property (take && req.kind == fbe_pkg::FBE_CMD_BOOST
        && req.lone && write_enable_latch_flag_q |=> boost_q)
        else $error("boost not set");
    flag_clear_a: assert property (busy_q && op_done &&
        op_kind_q != fbe_pkg::FBE_CMD_PGM |=> !boost_q) else $error("boost kept");
    latch_clear_a: assert property (busy_q && op_done |=> !busy_q
        && !write_enable_latch_flag_q)
        else $error("latch kept");
    no_sleep_a: assert property (!deep_pd_q) else $error("deep sleep");
    power_up_a: assert property ($rose(rstn) |-> !boost_q
        && !write_enable_latch_flag_q && !ready_q)
        else $error("bad power-up state");
    read_take_a: assert property (take && req.kind == fbe_pkg::FBE_CMD_READ
        |=> read_ok_q) else $error("read refused");
    latch_need_a: assert property (take && !write_enable_latch_flag_q
        |=> !start_q)
        else $error("start without latch");
    ready_time_a: assert property ($rose(rstn) |-> ##[1:SETTLE_CYC] ready_q)
        else $error("settle too long");
endmodule
bind fbe_core fbe_checker #(.SETTLE_CYC(SETTLE_CYC)) chk (.*);
`default_nettype wire

// file: test/fbe_host.sv
`timescale 1ns/1ns
`default_nettype none
module fbe_host (
    input wire logic              clk,  // Core clock
    input wire fbe_pkg::fbe_cmd_t kind, // Command to frame
    input wire logic              lone, // Select rises after code byte
    input wire logic              go,   // Issue one command
    output fbe_pkg::fbe_req_t     req   // Framed command to the core
);
    // lone framing; idle kind inverted so stale codes never linger
    always_ff @(negedge clk)
        req <= go ? {1'b1, lone, kind} : {2'b0, ~kind};
endmodule
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 0, rstn = 0, op_done = 0, lone = 0, go = 0;
    logic ready_q, busy_q, deep_pd_q, boost_q, start_q, fast_q;
    logic write_enable_latch_flag_q, read_ok_q;
    fbe_pkg::fbe_cmd_t kind = fbe_pkg::FBE_CMD_NONE, op_kind_q;
    fbe_pkg::fbe_req_t req;
    int bad_count = 0, n_tests = 0;
    initial forever #50 clk = ~clk;
    fbe_host host (.clk(clk), .kind(kind), .lone(lone), .go(go), .req(req));
    fbe_core #(.SETTLE_CYC(10)) dut (.*);
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %0t %h %h", $time, g, e);
        end
    endtask
    // host issues one framed command at a time
    task automatic send(input fbe_pkg::fbe_cmd_t k, input logic l);
        @(negedge clk);
        kind <= k;
        lone <= l;
        go   <= 1'b1;
        @(negedge clk);
        go <= 1'b0;
        @(negedge clk);
    endtask
    // Power cycle; deliberate early commands must be dropped
    task automatic pwr;
        rstn <= 1'b0;
        send(fbe_pkg::FBE_CMD_WLS, 0);
        chk(write_enable_latch_flag_q, 0);
        chk({boost_q, deep_pd_q, ready_q}, 0);
        rstn <= 1'b1;
        send(fbe_pkg::FBE_CMD_READ, 0);
        chk(read_ok_q, 0);
        repeat (6) @(negedge clk);
        chk(ready_q, 0);
        @(negedge clk);
        chk(ready_q, 1);
        send(fbe_pkg::FBE_CMD_READ, 0);
        chk(read_ok_q, 1);
    endtask
    task automatic boost(input fbe_pkg::fbe_cmd_t k);
        send(fbe_pkg::FBE_CMD_WLS, 0);
        send(fbe_pkg::FBE_CMD_BOOST, 1);
        chk(boost_q, 1);
        send(k, 0);
        chk({start_q, fast_q, busy_q}, 8'h07);
        chk(op_kind_q, k);
        @(negedge clk) op_done <= 1;
        @(negedge clk) op_done <= 0;
        @(negedge clk);
        chk({boost_q, busy_q, fast_q}, 0);
        chk(write_enable_latch_flag_q, 0);
    endtask
    // Program: not accelerated, boost kept, busy refuses reads
    task automatic prog;
        send(fbe_pkg::FBE_CMD_WLS, 0);
        send(fbe_pkg::FBE_CMD_BOOST, 1);
        send(fbe_pkg::FBE_CMD_PGM, 0);
        chk({start_q, fast_q, busy_q}, 8'h05);
        chk(op_kind_q, fbe_pkg::FBE_CMD_PGM);
        send(fbe_pkg::FBE_CMD_READ, 0);
        chk(read_ok_q, 0);
        @(negedge clk) op_done <= 1;
        @(negedge clk) op_done <= 0;
        @(negedge clk);
        chk({boost_q, busy_q}, 8'h02);
        chk(write_enable_latch_flag_q, 0);
    endtask
    task automatic refuse;
        send(fbe_pkg::FBE_CMD_BE64, 0);
        chk(start_q, 0);
        send(fbe_pkg::FBE_CMD_WLS, 0);
        send(fbe_pkg::FBE_CMD_BOOST, 0);
        chk(boost_q, 0);
        send(fbe_pkg::FBE_CMD_BOOST, 1);
        pwr;
    endtask
    task automatic report_and_stop;
        if (bad_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        pwr;
        boost(fbe_pkg::FBE_CMD_BE64);
        boost(fbe_pkg::FBE_CMD_CE);
        refuse;
        prog;
        report_and_stop;
    end
    // Cut a hang well past the expected run
    initial begin
        repeat (2000) @(posedge clk);
        bad_count++;
        report_and_stop;
    end
endmodule
`default_nettype wire
